// ===== hdl/serial_audio_port.v
`timescale 1ns/1ps
`include "serial_audio_port_regs.vh"

module serial_audio_port (
   input  wire        clock,
   input  wire        rst_n,
   input  wire        clockEnable,
   input  wire        hsel,
   input  wire [13:0] haddr,
   input  wire [1:0]  htrans,
   input  wire        hwrite,
   input  wire [2:0]  hsize,
   input  wire [31:0] hwdata,
   input  wire        hready,
   output wire [31:0] hrdata,
   output wire        hreadyout,
   output wire        hresp,
   input  wire        inBitClock,
   input  wire        inWordClock,
   input  wire [3:0]  serial_in_lines,
   input  wire        outBitClockIn,
   output wire        outBitClockOut,
   output wire        outBitClockOe_n,
   input  wire        outWordClockIn,
   output wire        outWordClockOut,
   output wire        outWordClockOe_n,
   output wire [3:0]  serial_out_lines,
   input  wire [23:0] txSample,
   output wire [2:0]  txSlot,
   output wire        txRequest,
   input  wire [2:0]  rxReadSlot,
   output wire [23:0] rxReadData,
   output wire        rxFrameDone
);

   // Control registers.
   reg [15:0] outCtrl_reg;
   reg [7:0]  inCtrl_reg;
   reg        busWrite_reg;
   reg [13:0] busAddr_reg;
   reg [31:0] rdata_reg;
   // Receive status is readable over the bus, so it is declared ahead of the bus logic.
   reg [2:0]  rxSlot_reg;
   reg        rxInFrame_reg;

   wire outWclkPol  = outCtrl_reg[`OUT_WCLK_POL];
   wire outBclkPol  = outCtrl_reg[`OUT_BCLK_POL];
   wire outMaster   = outCtrl_reg[`OUT_MASTER];
   wire [1:0] bDiv  = outCtrl_reg[`OUT_BDIV_HI:`OUT_BDIV_LO];
   wire [1:0] wDiv  = outCtrl_reg[`OUT_WDIV_HI:`OUT_WDIV_LO];
   wire outPulse    = outCtrl_reg[`OUT_PULSE];
   wire outTdm      = outCtrl_reg[`OUT_TDM];
   wire [2:0] msbSel = outCtrl_reg[`OUT_MSB_HI:`OUT_MSB_LO];
   wire [1:0] lenSel = outCtrl_reg[`OUT_LEN_HI:`OUT_LEN_LO];
   wire inWclkPol   = inCtrl_reg[`IN_WCLK_POL];
   wire inBclkPol   = inCtrl_reg[`IN_BCLK_POL];
   wire [2:0] inMode = inCtrl_reg[`IN_MODE_HI:`IN_MODE_LO];

   // The slave answers with zero wait states and always OKAY.
   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;
   assign hrdata    = rdata_reg;

   // Idle and busy cycles carry no transfer, so only the upper transfer-type bit is tested.
   wire addrPhase = hsel && hready && htrans[1];

   // Write data arrive one cycle after the address, so the address is held for the data phase.
   always @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         busWrite_reg <= 1'b0;
         busAddr_reg  <= 14'h0000;
         outCtrl_reg  <= `OUT_CTRL_RESET;
         inCtrl_reg   <= `IN_CTRL_RESET;
         rdata_reg    <= 32'h00000000;
      end else if (clockEnable) begin
         busWrite_reg <= addrPhase && hwrite;
         if (addrPhase) begin
            busAddr_reg <= haddr;
         end
         if (busWrite_reg && busAddr_reg == `OUT_CTRL_ADDR) begin
            outCtrl_reg <= hwdata[15:0] & `OUT_CTRL_MASK;
         end
         if (busWrite_reg && busAddr_reg == `IN_CTRL_ADDR) begin
            inCtrl_reg <= hwdata[7:0] & `IN_CTRL_MASK;
         end
         if (addrPhase && !hwrite) begin
            case (haddr)
               `OUT_CTRL_ADDR: rdata_reg <= {16'h0000, outCtrl_reg};
               `IN_CTRL_ADDR:  rdata_reg <= {24'h000000, inCtrl_reg};
               `STATUS_ADDR:   rdata_reg <= {28'h0000000, rxSlot_reg, rxInFrame_reg};
               default:        rdata_reg <= 32'h00000000;
            endcase
         end
      end
   end

   // ---- Output clock generation -------------------------------------------------
   // The core clock is modelled as the block clock; dividers count its cycles.
   reg [9:0] divCount_reg;
   wire [3:0] bHalf = (bDiv == 2'h0) ? 4'h8 : (bDiv == 2'h1) ? 4'h4 :
                      (bDiv == 2'h2) ? 4'h2 : 4'h1;
   wire [9:0] wPeriod = (wDiv == 2'h0) ? 10'h3ff : (wDiv == 2'h1) ? 10'h1ff
                                                  : 10'h0ff;
   wire [9:0] bMask = {6'h00, bHalf} - 10'h001;

   always @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         divCount_reg <= 10'h000;
      end else if (clockEnable) begin
         divCount_reg <= (divCount_reg >= wPeriod) ? 10'h000 : divCount_reg + 10'h001;
      end
   end

   // Master bit clock falls at count zero, so frame starts line up with falling edges.
   wire [9:0] bitPhase   = divCount_reg & ({bMask[8:0], 1'b1});
   wire       masterBclk = (bitPhase > bMask);
   wire       masterWlvl = divCount_reg > (wPeriod >> 1);
   wire [9:0] bitIndexM  = divCount_reg / {5'h00, bHalf, 1'b0};

   // The pulse is decoded from the counter rather than registered, so its first edge
   // lands on the same core cycle as a bit-clock fall and no frame start is missed while the bit-clock polarity bit is clear.
   wire       masterPulse = (bitIndexM == 10'h000);
   wire       squareOut   = outWclkPol ? masterWlvl : ~masterWlvl;
   wire       pulseLvl    = outWclkPol ? masterPulse : ~masterPulse;
   wire       masterWpin  = outPulse ? pulseLvl : squareOut;

   // Slave mode follows the pins; the output enables stay high until master is set.
   // In master mode the serialiser watches the pin level itself, so polarity and the
   // pulse form move the frame start exactly as an outside listener would see it.
   wire bclkNow = outMaster ? masterBclk : outBitClockIn;
   wire wclkNow = outMaster ? masterWpin : outWordClockIn;
   assign outBitClockOe_n  = ~outMaster;
   assign outWordClockOe_n = ~outMaster;
   assign outBitClockOut   = outMaster & masterBclk;

   // ---- Output serialiser -----------------------------------------------------
   reg        obPrev_reg;
   reg        owPrev_reg;
   reg [9:0]  oBit_reg;
   reg [3:0]  outData_reg;
   reg [23:0] shift_reg [0:3];
   reg [2:0]  txSlot_reg;
   reg        txReq_reg;

   // Change edge per polarity; a frame starts on the word-clock edge that polarity selects.
   wire obChange   = outBclkPol ? (bclkNow && !obPrev_reg) : (!bclkNow && obPrev_reg);
   wire owRise     = wclkNow && !owPrev_reg;
   wire owFall     = !wclkNow && owPrev_reg;
   wire frameStart = outWclkPol ? owRise : owFall;
   wire [4:0] msbDelay = (msbSel == 3'h0) ? 5'd1 : (msbSel == 3'h1) ? 5'd0 :
                         (msbSel == 3'h2) ? 5'd8 : (msbSel == 3'h3) ? 5'd12 : 5'd16;
   wire [4:0] wordLen  = (lenSel == 2'h0) ? 5'd24 : (lenSel == 2'h1) ? 5'd20 : 5'd16;
   // In stereo, slot 0 is the channel on the level where the frame starts.
   wire [9:0] nextBit  = frameStart ? 10'h000 : oBit_reg + 10'h001;
   wire [4:0] inSlot   = nextBit[4:0];
   wire [2:0] slotNum  = outTdm ? nextBit[7:5] : {2'b00, nextBit[5]};
   wire       slotEdge = (inSlot == msbDelay);

   // One bit period after the frame edge, the pulse drops again.
   always @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         obPrev_reg   <= 1'b0;
         owPrev_reg   <= 1'b0;
         oBit_reg     <= 10'h3ff;
         outData_reg  <= 4'h0;
         txSlot_reg   <= 3'h0;
         txReq_reg    <= 1'b0;
      end else if (clockEnable) begin
         obPrev_reg <= bclkNow;
         owPrev_reg <= wclkNow;
         txReq_reg  <= 1'b0;
         // The slot is tracked every cycle, so the sample source has a bit period less one core cycle
         // to answer before the shifter loads; a slot chosen at the load would come late.
         txSlot_reg <= slotNum;
         if (obChange) begin
            oBit_reg <= nextBit;
            if (slotEdge) begin
               txReq_reg  <= 1'b1;
            end
         end
         // The line shows the MSB at the load itself and the following bits afterwards,
         // so the MSB appears exactly the selected number of bit clocks after the frame edge.
         if (obChange) begin
            outData_reg <= nextOut;
         end
      end
   end

   // Per-line shifters: load at the MSB position, then shift MSB first, zero after the LSB.
   // Bits below the word length are cleared at the load, so a long sample never leaks.
   wire [23:0] newWord = txSample & ~(24'hffffff >> wordLen);
   wire [3:0]  nextOut;
   genvar line;
   generate
      for (line = 0; line < 4; line = line + 1) begin : txLine
         // In TDM only the first line takes new words; the others run out to zero.
         wire loadHere = slotEdge && (line == 0 || !outTdm);
         assign nextOut[line] = loadHere ? newWord[23] : shift_reg[line][22];
         always @(posedge clock or negedge rst_n) begin
            if (!rst_n) begin
               shift_reg[line] <= 24'h000000;
            end else if (clockEnable && obChange) begin
               if (loadHere) begin
                  shift_reg[line] <= newWord;
               end else begin
                  shift_reg[line] <= {shift_reg[line][22:0], 1'b0};
               end
            end
         end
      end
   endgenerate

   // TDM keeps only the first line active; the other lines sit low.
   assign serial_out_lines = outTdm ? {3'b000, outData_reg[0]} : outData_reg;
   assign txSlot    = txSlot_reg;
   assign txRequest = txReq_reg;

   // The word-clock pin carries the master level only; as a slave it sits low.
   assign outWordClockOut = outMaster & masterWpin;

   // ---- Input deserialiser --------------------------------------------------
   // Input clocks are only ever sampled, never driven.
   reg        ibPrev_reg;
   reg        iwPrev_reg;
   reg [9:0]  iBit_reg;
   reg [23:0] rxShift_reg;
   reg [4:0]  rxCount_reg;
   reg        iwPend_reg;
   reg        rxWrite_reg;
   reg [2:0]  rxWAddr_reg;
   reg [23:0] rxWData_reg;
   reg        rxDone_reg;

   wire inTdm    = (inMode == `MODE_TDM);
   wire inRj     = (inMode >= `MODE_RJ24);
   wire ibSample = inBclkPol ? (!inBitClock && ibPrev_reg) : (inBitClock && !ibPrev_reg);
   wire iwRise   = inWordClock && !iwPrev_reg;
   wire iwFall   = !inWordClock && iwPrev_reg;
   wire iwStart  = inWclkPol ? iwRise : iwFall;
   wire iwAny    = iwRise || iwFall;
   // Right-justified words end on the last bit of a 32-bit half frame, so the MSB waits
   // 32 minus the word length; this only holds with 64 bit clocks to the frame.
   wire [4:0] rjDelay = (inMode == `MODE_RJ24) ? 5'd8 : (inMode == `MODE_RJ20) ? 5'd12 :
                        (inMode == `MODE_RJ18) ? 5'd14 : 5'd16;
   wire [4:0] inDelay = (inMode == `MODE_LJ) ? 5'd0 : inRj ? rjDelay : 5'd1;
   // A word-clock edge seldom falls in the same core cycle as a sample edge, so it is
   // remembered until the next sample edge restarts the bit count.
   wire       frameEvt = inTdm ? iwStart : iwAny;
   wire [9:0] iNext   = (frameEvt || iwPend_reg) ? 10'h000 : iBit_reg + 10'h001;
   // Stereo channel follows the word-clock level and polarity.
   wire       rightCh = inWclkPol ? ~inWordClock : inWordClock;
   wire [2:0] iSlot   = inTdm ? iNext[7:5] : {2'b00, rightCh};
   wire [4:0] iPos    = inTdm ? iNext[4:0] : iNext[4:0];
   wire       iLast   = (iPos == 5'd31);

   always @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         ibPrev_reg    <= 1'b0;
         iwPrev_reg    <= 1'b0;
         iBit_reg      <= 10'h3ff;
         rxShift_reg   <= 24'h000000;
         rxCount_reg   <= 5'd0;
         rxSlot_reg    <= 3'h0;
         rxInFrame_reg <= 1'b0;
         iwPend_reg    <= 1'b0;
         rxWrite_reg   <= 1'b0;
         rxWAddr_reg   <= 3'h0;
         rxWData_reg   <= 24'h000000;
         rxDone_reg    <= 1'b0;
      end else if (clockEnable) begin
         ibPrev_reg  <= inBitClock;
         iwPrev_reg  <= inWordClock;
         rxWrite_reg <= 1'b0;
         rxDone_reg  <= 1'b0;
         // The sample edge consumes a pending frame start; otherwise a new edge arms it.
         if (ibSample) begin
            iwPend_reg <= 1'b0;
         end else if (frameEvt) begin
            iwPend_reg <= 1'b1;
         end
         if (ibSample) begin
            iBit_reg      <= iNext;
            rxSlot_reg    <= iSlot;
            rxInFrame_reg <= 1'b1;
            if (iPos == inDelay) begin
               rxShift_reg <= {serial_in_lines[0], 23'h000000};
               rxCount_reg <= 5'd1;
            end else if (rxCount_reg != 5'd0 && rxCount_reg < `MAX_WORD_BITS) begin
               rxShift_reg <= rxShift_reg | ({serial_in_lines[0], 23'h000000} >> rxCount_reg);
               rxCount_reg <= rxCount_reg + 5'd1;
            end
            if (iLast) begin
               rxWrite_reg <= 1'b1;
               rxWAddr_reg <= iSlot;
               rxWData_reg <= rxShift_reg;
               rxCount_reg <= 5'd0;
               rxDone_reg  <= inTdm ? (iSlot == 3'h7) : (iSlot == 3'h1);
            end
         end
      end
   end

   sample_store rxStore (
      .clock       (clock),
      .clockEnable (clockEnable),
      .writeEnable (rxWrite_reg),
      .writeAddr   (rxWAddr_reg),
      .writeData   (rxWData_reg),
      .readAddr    (rxReadSlot),
      .readData    (rxReadData)
   );

   assign rxFrameDone = rxDone_reg;

endmodule

// ===== hdl/serial_audio_port_regs.vh
`ifndef SERIAL_AUDIO_PORT_REGS_VH
`define SERIAL_AUDIO_PORT_REGS_VH

// Register byte addresses. Printed offsets are kept as indexes; the byte address is four times.
`define IN_CTRL_INDEX        12'h81f
`define OUT_CTRL_INDEX       12'h81e
`define IN_CTRL_ADDR         14'h207c
`define OUT_CTRL_ADDR        14'h2078
`define STATUS_ADDR          14'h2080

// Output control fields.
`define OUT_WCLK_POL         13
`define OUT_BCLK_POL         12
`define OUT_MASTER           11
`define OUT_BDIV_HI          10
`define OUT_BDIV_LO          9
`define OUT_WDIV_HI          8
`define OUT_WDIV_LO          7
`define OUT_PULSE            6
`define OUT_TDM              5
`define OUT_MSB_HI           4
`define OUT_MSB_LO           2
`define OUT_LEN_HI           1
`define OUT_LEN_LO           0
`define OUT_CTRL_MASK        16'h3fff
`define OUT_CTRL_RESET       16'h0000

// Input control fields.
`define IN_WCLK_POL          4
`define IN_BCLK_POL          3
`define IN_MODE_HI           2
`define IN_MODE_LO           0
`define IN_CTRL_MASK         8'h1f
`define IN_CTRL_RESET        8'h00

// Input modes.
`define MODE_I2S             3'h0
`define MODE_LJ              3'h1
`define MODE_TDM             3'h2
`define MODE_RJ24            3'h3
`define MODE_RJ20            3'h4
`define MODE_RJ18            3'h5
`define MODE_RJ16            3'h6

// Timing: core clock and the receive sample width.
`define CORE_CLOCK_HZ        49152000
`define MAX_WORD_BITS        24
`define RJ_FRAME_BCLKS       64

`endif

// ===== hdl/sample_store.v
`timescale 1ns/1ps

// Eight-entry sample memory; read data come out of a register.
module sample_store (
   input  wire        clock,
   input  wire        clockEnable,
   input  wire        writeEnable,
   input  wire [2:0]  writeAddr,
   input  wire [23:0] writeData,
   input  wire [2:0]  readAddr,
   output reg  [23:0] readData
);

   reg [23:0] store [0:7];

   // Storage has no reset; the read register does not need one either.
   always @(posedge clock) begin
      if (clockEnable) begin
         if (writeEnable) begin
            store[writeAddr] <= writeData;
         end
         readData <= store[readAddr];
      end
   end

endmodule

// ===== verification/serial_audio_port_asserts.sv
`timescale 1ns/1ps

// Watches the bus answer, the output clock pins and the one-cycle strobes.
module serial_audio_port_asserts (
   input wire        clock,
   input wire        rst_n,
   input wire [31:0] hrdata,
   input wire        hreadyout,
   input wire        hresp,
   input wire        outBitClockOut,
   input wire        outBitClockOe_n,
   input wire        outWordClockOut,
   input wire        outWordClockOe_n,
   input wire        txRequest,
   input wire        rxFrameDone
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_n);
   logic [3:0]  bRun;
   logic [10:0] wRun;
   logic        bPrev;
   logic        wPrev;

   // Run length of each clock level, cleared while the pins are inputs so a stuck clock shows.
   always @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         bRun <= 4'h0;
         wRun <= 11'h000;
         bPrev <= 1'b0;
         wPrev <= 1'b0;
      end else begin
         bPrev <= outBitClockOut;
         wPrev <= outWordClockOut;
         bRun <= (outBitClockOe_n || outBitClockOut != bPrev) ? 4'h0 : bRun + 4'h1;
         wRun <= (outWordClockOe_n || outWordClockOut != wPrev) ? 11'h000 : wRun + 11'h001;
      end
   end

   oe_pair_a: assert property (outBitClockOe_n == outWordClockOe_n)
      else $error("clock pin enables differ");
   bclk_idle_a: assert property (outBitClockOe_n |-> !outBitClockOut)
      else $error("bit clock driven while slave");
   wclk_idle_a: assert property (outWordClockOe_n |-> !outWordClockOut)
      else $error("word clock driven while slave");
   bclk_rate_a: assert property (!outBitClockOe_n |-> bRun < 4'h8)
      else $error("bit clock half period too long");
   wclk_rate_a: assert property (!outWordClockOe_n |-> wRun < 11'h400)
      else $error("word clock level longer than a frame");
   rdata_top_a: assert property (hrdata[31:16] == 16'h0000)
      else $error("unused read bits not zero");
   bus_okay_a: assert property (hreadyout && !hresp)
      else $error("bus answer not ready and okay");
   txreq_pulse_a: assert property (txRequest |=> !txRequest)
      else $error("sample request longer than one cycle");
   frame_pulse_a: assert property ($rose(rxFrameDone) |=> $fell(rxFrameDone))
      else $error("frame done longer than one cycle");
endmodule

bind serial_audio_port serial_audio_port_asserts serial_audio_port_asserts_inst (
   .clock(clock), .rst_n(rst_n), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
   .outBitClockOut(outBitClockOut), .outBitClockOe_n(outBitClockOe_n),
   .outWordClockOut(outWordClockOut), .outWordClockOe_n(outWordClockOe_n),
   .txRequest(txRequest), .rxFrameDone(rxFrameDone));

// ===== verification/audio_source.sv
`timescale 1ns/1ps

// External converter: free-running input clocks, slot k carries base plus k.
module audio_source (
   input  wire        clock,
   input  wire        rst_n,
   input  wire        tdm,
   input  wire [23:0] base,
   output wire        bitClock,
   output wire        wordClock,
   output wire [3:0]  dataLines
);
   logic [10:0] cnt;
   wire  [2:0]  slot = tdm ? cnt[10:8] : {2'h0, cnt[8]};
   wire  [4:0]  pos = cnt[7:3];
   wire  [23:0] word = base + {21'h0, slot};

   // One bit clock is eight block clocks; data and word clock move on its falling edge.
   always @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         cnt <= 11'h000;
      end else begin
         cnt <= cnt + 11'h001;
      end
   end

   // Both clocks come from this side; the low half of the word clock opens the frame.
   assign bitClock = cnt[2];
   assign wordClock = tdm ? cnt[10] : cnt[8];
   // MSB one bit after the slot starts, zeros after the LSB; spare lines keep toggling.
   assign dataLines[0] = (pos >= 5'h01 && pos <= 5'h18) ? word[5'h18 - pos] : 1'b0;
   assign dataLines[3:1] = cnt[5:3];
endmodule

// ===== verification/serial_audio_port_tb.sv
`timescale 1ns/1ps
`include "serial_audio_port_regs.vh"

// Drives the control bus, measures the master clocks and compares serial samples.
module serial_audio_port_tb;
   logic        clock = 1'b0;
   logic        rst_n = 1'b0;
   logic        hsel = 1'b0;
   logic [13:0] haddr = 14'h0000;
   logic [1:0]  htrans = 2'h0;
   logic        hwrite = 1'b0;
   logic [31:0] hwdata = 32'h00000000;
   logic [2:0]  rxReadSlot = 3'h0;
   logic        tdm = 1'b0;
   logic [23:0] base = 24'h000000;
   logic [31:0] q;
   logic [31:0] d;
   logic [23:0] s;
   wire  [31:0] hrdata;
   wire         hreadyout, hresp, inBitClock, inWordClock, bOut, bOe_n, wOut, wOe_n;
   wire  [3:0]  inLines, outLines;
   wire  [23:0] txSample, rxReadData;
   wire  [2:0]  txSlot;
   wire         txRequest, rxFrameDone;
   int          err_total = 0;
   int          comparisons = 0;
   int          hi, per, i;
   // A pin the design does not drive shows the external clock.
   wire         bPin = bOe_n ? inBitClock : bOut;
   wire         wPin = wOe_n ? inWordClock : wOut;

   assign txSample = {txSlot, 5'h15, txSlot, 13'h0b3c};
   always #20 clock = ~clock;

   serial_audio_port serial_audio_port_inst (
      .clock(clock), .rst_n(rst_n), .clockEnable(1'b1), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .inBitClock(inBitClock),
      .inWordClock(inWordClock), .serial_in_lines(inLines), .outBitClockIn(bPin),
      .outBitClockOut(bOut), .outBitClockOe_n(bOe_n), .outWordClockIn(wPin),
      .outWordClockOut(wOut), .outWordClockOe_n(wOe_n), .serial_out_lines(outLines),
      .txSample(txSample), .txSlot(txSlot), .txRequest(txRequest),
      .rxReadSlot(rxReadSlot), .rxReadData(rxReadData), .rxFrameDone(rxFrameDone));

   audio_source audio_source_inst (.clock(clock), .rst_n(rst_n), .tdm(tdm), .base(base),
      .bitClock(inBitClock), .wordClock(inWordClock), .dataLines(inLines));

   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] v);
      comparisons++;
      if (v !== e) begin
         err_total++;
         $display("unexpected %s expected %h seen %h", nm, e, v);
      end
   endtask

   // One single word: address phase, then data phase; read data taken at its closing edge.
   task automatic bus(input logic wr, input logic [13:0] a, input logic [31:0] w);
      @(posedge clock);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= a;
      hwrite <= wr;
      do @(posedge clock); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hwdata <= w;
      do @(posedge clock); while (hreadyout !== 1'b1);
      q = hrdata;
   endtask

   // Passing through slave first clears every output control field; the dividers keep counting.
   task automatic cfg(input logic [31:0] w);
      bus(1'b1, `OUT_CTRL_ADDR, 32'h0);
      bus(1'b1, `OUT_CTRL_ADDR, w);
   endtask

   // Period and high time of one clock, sampled on block clock edges.
   task automatic measure(input bit sel);
      int k, st;
      logic p, c;
      st = -1;
      per = 0;
      hi = 0;
      p = 1'b1;
      for (k = 0; k < 3000 && per == 0; k++) begin
         @(posedge clock);
         c = sel ? wOut : bOut;
         if (c && !p && st >= 0) per = k - st;
         if (c && !p && st < 0) st = k;
         if (st >= 0 && per == 0 && c) hi++;
         p = c;
      end
   endtask

   task automatic capture(output logic [31:0] v);
      int k;
      v = 32'h0;
      @(negedge wOut);
      for (k = 0; k < 32; k++) begin
         @(posedge bOut);
         v = {v[30:0], outLines[0]};
      end
   endtask

   task automatic rxcheck(input int n, input int sw);
      int k, t;
      for (k = 0; k < 2; k++) begin
         @(posedge clock);
         for (t = 0; t < 5000 && rxFrameDone !== 1'b1; t++) @(posedge clock);
      end
      for (k = 0; k < n; k++) begin
         rxReadSlot <= k[2:0];
         repeat (3) @(posedge clock);
         chk("rx slot", {8'h0, base + (k[23:0] ^ sw[23:0])}, {8'h0, rxReadData});
      end
   endtask

   task automatic complete_run();
      $display("comparisons %0d err_total %0d", comparisons, err_total);
      if (err_total == 0 && comparisons > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   // The whole sequence needs about half a millisecond.
   initial begin
      #3000000;
      err_total++;
      complete_run();
   end

   initial begin
      void'($urandom(65430));
      repeat (12) @(posedge clock);
      rst_n <= 1'b1;
      bus(1'b0, `OUT_CTRL_ADDR, 32'h0);
      chk("out reset", `OUT_CTRL_RESET, q);
      bus(1'b0, `IN_CTRL_ADDR, 32'h0);
      chk("in reset", `IN_CTRL_RESET, q);
      chk("slave pins", 32'h3, {bOe_n, wOe_n});
      // Random fields with the master bit kept clear; unused bits must drop.
      for (i = 0; i < 4; i++) begin
         d = $urandom & 32'hfffff7ff;
         bus(1'b1, `OUT_CTRL_ADDR, d);
         bus(1'b0, `OUT_CTRL_ADDR, 32'h0);
         chk("out ctrl", d & `OUT_CTRL_MASK, q);
         bus(1'b1, `IN_CTRL_ADDR, d);
         bus(1'b0, `IN_CTRL_ADDR, 32'h0);
         chk("in ctrl", d & `IN_CTRL_MASK, q);
         bus(1'b1, 14'h0004, d);
         bus(1'b0, 14'h0004, 32'h0);
         chk("unmapped", 32'h0, q);
      end
      for (i = 0; i < 4; i++) begin
         cfg(32'h800 | (i << 9));
         measure(1'b0);
         chk("bclk period", 16 >> i, per);
         chk("master pins", 32'h0, {bOe_n, wOe_n});
      end
      // Three word clock dividers, then the high pulse form.
      for (i = 0; i < 4; i++) begin
         cfg((i == 3) ? 32'h2840 : 32'h800 | (i << 7));
         measure(1'b1);
         chk("wclk period", (i == 3) ? 1024 : 1024 >> i, per);
         chk("wclk high", (i == 3) ? 16 : 512 >> i, hi);
      end
      s = {3'h0, 5'h15, 3'h0, 13'h0b3c};
      for (i = 0; i < 2; i++) begin
         cfg(i ? 32'h806 : 32'h800);
         capture(d);
         capture(d);
         chk("left word", i ? {s[23:8], 16'h0} : {1'b0, s, 7'h0}, d);
      end
      cfg(32'h820);
      for (i = 0; i < 100; i++) begin
         @(posedge clock);
         chk("tdm spare lines", 32'h0, {29'h0, outLines[3:1]});
      end
      base <= $urandom;
      bus(1'b1, `IN_CTRL_ADDR, {29'h0, `MODE_I2S});
      rxcheck(2, 0);
      bus(1'b1, `IN_CTRL_ADDR, 32'h10);
      rxcheck(2, 1);
      tdm <= 1'b1;
      bus(1'b1, `IN_CTRL_ADDR, {29'h0, `MODE_TDM});
      rxcheck(8, 0);
      complete_run();
   end
endmodule
